// [hbp_pkg.sv]
// Package for the processor-side host bus port of the USB slave controller.
// Assumes a single 250 MHz clock domain with every pin sampled synchronously.
package hbp_pkg;
	// Bus and memory geometry
	localparam int unsigned HBP_DATA_W   = 8;
	localparam int unsigned HBP_ADDR_W   = 8;
	localparam int unsigned HBP_MEM_DEPTH = 256;
	// Clock rates for the multiplier
	localparam int unsigned HBP_CLK_MHZ      = 250;
	localparam int unsigned HBP_REF_SLOW_MHZ = 12;
	localparam int unsigned HBP_REF_FAST_MHZ = 48;
	localparam int unsigned HBP_PLL_FACTOR   = 4;
	// Values after reset
	localparam logic [7:0]  HBP_PTR_RST      = 8'h00;
	localparam logic [7:0]  HBP_DATA_RST     = 8'h00;
	localparam logic [15:0] HBP_DMA_CNT_RST  = 16'h0000;
	// Pointer/data select levels
	localparam logic HBP_SEL_POINTER = 1'b0;
	localparam logic HBP_SEL_DATA    = 1'b1;

	// Host-side pins sampled each cycle
	typedef struct packed {
		logic                  pointer_or_data_select;
		logic                  write_strobe_n;
		logic                  read_strobe_n;
		logic                  chip_select_n;
		logic [HBP_DATA_W-1:0] data;
	} hbp_host_s;

	// DMA job as given by the core
	typedef struct packed {
		logic                  start;
		logic                  to_memory;
		logic [HBP_ADDR_W-1:0] base;
		logic [15:0]           count;
	} hbp_dma_job_s;

	typedef enum logic [1:0] {
		HBP_DMA_IDLE,
		HBP_DMA_REQ,
		HBP_DMA_XFER
	} hbp_dma_state_e;
endpackage

// [hbp_host_port.sv]
// Host bus port: 8-bit multiplexed data/pointer bus, DMA handshake, interrupt
// and clock mode pins. Assumes all pins are synchronous to clk_i.
module hbp_host_port
	import hbp_pkg::*;
#(
	parameter int unsigned DEPTH = HBP_MEM_DEPTH
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	// Host bus pins
	input  wire hbp_host_s             host_i,
	output logic [HBP_DATA_W-1:0]      data_o,
	output logic                       data_oe_n_o,
	// DMA pins
	output logic                       dma_request_n_o,
	input  wire logic                  dma_grant_n_i,
	// Interrupt and clock mode pins
	output logic                       irq_out_o,
	input  wire logic                  clock_multiplier_select_i,
	// Core side
	input  wire logic                  irq_pending_i,
	input  wire hbp_dma_job_s          dma_job_i,
	output logic                       dma_done_o,
	output logic                       pll_enable_o,
	input  wire logic [HBP_ADDR_W-1:0] core_addr_i,
	output logic [HBP_DATA_W-1:0]      core_rdata_o,
	output logic [HBP_ADDR_W-1:0]      pointer_o
);
	// Core clock that the multiplier must yield
	localparam int unsigned PLL_OUT_MHZ = HBP_REF_SLOW_MHZ * HBP_PLL_FACTOR;

	logic [HBP_DATA_W-1:0] mem_r [DEPTH];
	logic [HBP_ADDR_W-1:0] ptr_r;
	logic                  wr_act_d_r;
	logic [HBP_ADDR_W-1:0] dma_ptr_r;
	logic [15:0]           dma_left_r;
	logic                  dma_dir_r;
	logic                  dma_act_d_r;
	hbp_dma_state_e        dma_st_r;
	logic                  pll_en_r;
	logic                  irq_r;
	logic                  dma_done_r;

	// Chip select qualifies both strobes
	logic host_wr_act;
	logic host_rd_act;
	logic host_wr_evt;
	logic dma_strobe;
	logic dma_evt;
	assign host_wr_act = !host_i.chip_select_n && !host_i.write_strobe_n;
	assign host_rd_act = !host_i.chip_select_n && !host_i.read_strobe_n;
	assign host_wr_evt = host_wr_act && !wr_act_d_r;
	// A DMA cycle is a strobe seen while the grant is low; no chip select needed
	assign dma_strobe  = (dma_st_r == HBP_DMA_XFER) && !dma_grant_n_i
		&& (dma_dir_r ? !host_i.write_strobe_n : !host_i.read_strobe_n);
	assign dma_evt     = dma_strobe && !dma_act_d_r;

	// Edge memory so a long strobe counts once
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wr_act_d_r  <= 1'b0;
			dma_act_d_r <= 1'b0;
		end else begin
			wr_act_d_r  <= host_wr_act;
			dma_act_d_r <= dma_strobe;
		end
	end

	// Pointer register, loaded from the shared data lines
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ptr_r <= HBP_PTR_RST;
		end else if (host_wr_evt && host_i.pointer_or_data_select == HBP_SEL_POINTER) begin
			ptr_r <= host_i.data[HBP_ADDR_W-1:0];
		end
	end

	// Buffer memory; host write wins over a DMA byte in the same cycle
	always_ff @(posedge clk_i) begin
		if (host_wr_evt && host_i.pointer_or_data_select == HBP_SEL_DATA) begin
			mem_r[ptr_r] <= host_i.data;
		end else if (dma_evt && dma_dir_r) begin
			mem_r[dma_ptr_r] <= host_i.data;
		end
	end

	// Read data; the pointer itself is never returned
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			data_o       <= HBP_DATA_RST;
			core_rdata_o <= HBP_DATA_RST;
		end else begin
			// A DMA read byte is staged while the request is still pending, so the first
			// strobe already finds it; a host read in that window sees the DMA byte too
			data_o       <= (dma_st_r != HBP_DMA_IDLE && !dma_dir_r) ? mem_r[dma_ptr_r]
				: mem_r[ptr_r];
			core_rdata_o <= mem_r[core_addr_i];
		end
	end

	// Bus driven only during a qualified data read or a DMA read
	assign data_oe_n_o = !((host_rd_act && host_i.pointer_or_data_select == HBP_SEL_DATA)
		|| (dma_strobe && !dma_dir_r));

	// DMA handshake: request held low until the byte count runs out
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			dma_st_r   <= HBP_DMA_IDLE;
			dma_ptr_r  <= HBP_PTR_RST;
			dma_left_r <= HBP_DMA_CNT_RST;
			dma_dir_r  <= 1'b0;
			dma_done_r <= 1'b0;
		end else begin
			dma_done_r <= 1'b0;
			unique case (dma_st_r)
				HBP_DMA_IDLE: begin
					if (dma_job_i.start && dma_job_i.count != HBP_DMA_CNT_RST) begin
						dma_ptr_r  <= dma_job_i.base;
						dma_left_r <= dma_job_i.count;
						dma_dir_r  <= dma_job_i.to_memory;
						dma_st_r   <= HBP_DMA_REQ;
					end
				end
				HBP_DMA_REQ: begin
					if (!dma_grant_n_i) begin
						dma_st_r <= HBP_DMA_XFER;
					end
				end
				HBP_DMA_XFER: begin
					if (dma_evt) begin
						dma_ptr_r  <= dma_ptr_r + 8'h01;
						dma_left_r <= dma_left_r - 16'h0001;
						if (dma_left_r == 16'h0001) begin
							dma_st_r   <= HBP_DMA_IDLE;
							dma_done_r <= 1'b1;
						end
					end else if (dma_grant_n_i && !dma_act_d_r) begin
						dma_st_r <= HBP_DMA_REQ;
					end
				end
			endcase
		end
	end
	assign dma_request_n_o = !(dma_st_r != HBP_DMA_IDLE);
	assign dma_done_o      = dma_done_r;

	// Clock mode and interrupt pins registered so they settle glitch free
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pll_en_r <= 1'b0;
			irq_r    <= 1'b0;
		end else begin
			pll_en_r <= clock_multiplier_select_i;
			irq_r    <= irq_pending_i;
		end
	end
	assign pll_enable_o = pll_en_r;
	assign irq_out_o    = irq_r;
	assign pointer_o    = ptr_r;

	// Checks
	initial begin
		a_pll_ratio: assert (PLL_OUT_MHZ == HBP_REF_FAST_MHZ)
			else $error("multiplier does not reach the fast reference");
	end
	a_ptr_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		host_wr_evt && !host_i.pointer_or_data_select |=> ptr_r == $past(host_i.data))
		else $error("pointer not loaded from bus");
	a_ptr_unread: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		host_rd_act && !host_i.pointer_or_data_select && dma_st_r != HBP_DMA_XFER
		|-> data_oe_n_o) else $error("pointer read drove the bus");
	a_data_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		host_rd_act && host_i.pointer_or_data_select |-> !data_oe_n_o)
		else $error("data read did not drive bus");
	a_cs_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		host_i.chip_select_n && !dma_strobe |-> data_oe_n_o)
		else $error("bus driven without chip select");
	a_ptr_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!host_wr_act |=> $stable(ptr_r)) else $error("pointer changed without write");
	a_wr_readback: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		host_wr_evt && host_i.pointer_or_data_select ##1 !host_wr_act [*2]
		|-> data_o == $past(host_i.data, 2)) else $error("written byte not read back");
	a_irq_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rst_b_i |=> irq_out_o == $past(irq_pending_i)) else $error("interrupt not followed");
	a_pll_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rst_b_i |=> pll_enable_o == $past(clock_multiplier_select_i))
		else $error("clock mode not followed");
	a_grant_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		dma_st_r == HBP_DMA_REQ && dma_grant_n_i |=> dma_st_r == HBP_DMA_REQ)
		else $error("transfer began without grant");
	a_dma_rd_data: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		dma_strobe && !dma_dir_r |-> !data_oe_n_o && data_o == mem_r[dma_ptr_r])
		else $error("DMA read byte not on the bus");
	a_dma_req: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		dma_job_i.start && dma_st_r == HBP_DMA_IDLE && dma_job_i.count != 16'h0000
		|=> !dma_request_n_o) else $error("DMA request not raised");
	a_dma_pace: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		dma_evt && dma_left_r == 16'h0001 |=> dma_request_n_o && dma_done_o)
		else $error("DMA did not end on last byte");
	// Covers for the main scenarios
	c_ptr_write:  cover property (@(posedge clk_i) host_wr_evt && !host_i.pointer_or_data_select);
	c_dma_read:   cover property (@(posedge clk_i) dma_strobe && !dma_dir_r);
	c_data_read:  cover property (@(posedge clk_i) host_rd_act && host_i.pointer_or_data_select);
	c_dma_finish: cover property (@(posedge clk_i) dma_done_o);
endmodule

// [hbp_dma_peer.sv]
// Behavioural DMA controller that answers the port's request line.
// Assumes the bench merges its strobe and data into the host bus pins.
module hbp_dma_peer
	import hbp_pkg::*;
#(
	parameter int unsigned LAT = 2
) (
	// Clock
	input  wire logic             clk_i,
	// Handshake and data
	input  wire logic             dma_request_n_i,
	output logic                  dma_grant_n_o,
	output logic                  strobe_n_o,
	output logic [HBP_DATA_W-1:0] data_o
);
	logic [3:0] wait_r = 4'h0;
	logic       grant_r = 1'b1;
	logic       strb_r = 1'b1;
	logic [7:0] cnt_r = 8'h00;
	// Grant after LAT idle cycles, then a strobe every other cycle
	always_ff @(posedge clk_i) begin
		if (dma_request_n_i) begin
			{grant_r, strb_r, wait_r} <= {2'b11, 4'h0};
		end else if (wait_r < LAT[3:0]) begin
			wait_r <= wait_r + 4'h1;
		end else begin
			grant_r <= 1'b0;
			strb_r  <= grant_r | ~strb_r;
			cnt_r   <= cnt_r + {7'h00, ~strb_r};
		end
	end
	// Gated by request so no strobe leaks once the port withdraws it
	assign dma_grant_n_o = grant_r | dma_request_n_i;
	assign strobe_n_o    = strb_r | dma_request_n_i;
	// Released bus shows the inverse, so a stale value never matches
	assign data_o = (8'h40 + cnt_r) ^ {8{strobe_n_o}};
endmodule

// [hbp_host_port_tb.sv]
// Self-checking bench for the host bus port.
// Assumes the DMA peer model is compiled alongside.
module hbp_host_port_tb;
	import hbp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic irq_i = 1'b0;
	logic mul_sel = 1'b0;
	logic dma_rd = 1'b0;
	logic [7:0] caddr = 8'h00;
	hbp_host_s bus_r = {4'h7, 8'h00};
	hbp_host_s host_w;
	hbp_dma_job_s job_r = '0;
	logic [7:0] dout, crd, ptr, pdat;
	logic oe_n, req_n, gnt_n, pstb_n, irq_o, done, pll;
	int err_count = 0;
	int n_tests = 0;
	always #2 clk_i = ~clk_i;
	// Peer strobe joins the write or read line by direction; its data only on writes
	assign host_w = {bus_r.pointer_or_data_select,
		bus_r.write_strobe_n & (pstb_n | dma_rd),
		bus_r.read_strobe_n & (pstb_n | ~dma_rd),
		bus_r.chip_select_n, (pstb_n | dma_rd) ? bus_r.data : pdat};
	hbp_host_port dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .host_i(host_w),
		.data_o(dout), .data_oe_n_o(oe_n), .dma_request_n_o(req_n),
		.dma_grant_n_i(gnt_n), .irq_out_o(irq_o), .clock_multiplier_select_i(mul_sel),
		.irq_pending_i(irq_i), .dma_job_i(job_r), .dma_done_o(done),
		.pll_enable_o(pll), .core_addr_i(caddr), .core_rdata_o(crd), .pointer_o(ptr));
	hbp_dma_peer peer_u (.clk_i(clk_i), .dma_request_n_i(req_n),
		.dma_grant_n_o(gnt_n), .strobe_n_o(pstb_n), .data_o(pdat));
	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// One strobe per byte, released a cycle later
	task automatic hw(logic cs_n, logic sel, logic [7:0] d);
		@(posedge clk_i);
		bus_r <= {sel, 1'b0, 1'b1, cs_n, d};
		@(posedge clk_i);
		bus_r <= {sel, 1'b1, 1'b1, 1'b1, d};
		@(posedge clk_i);
	endtask
	task automatic hr(logic cs_n, logic sel, logic eoe, logic [7:0] d);
		@(posedge clk_i);
		bus_r <= {sel, 1'b1, 1'b0, cs_n, 8'h00};
		tick(2);
		chk("bus enable", {7'h00, eoe}, {7'h00, oe_n});
		if (!eoe) chk("read data", d, dout);
		@(posedge clk_i);
		bus_r <= {4'h7, 8'h00};
	endtask
	task automatic t_ptr();
		hw(0, 0, 8'h5A);
		hw(0, 1, 8'hC3);
		hw(0, 0, 8'h5B);
		hw(0, 1, 8'h3C);
		hw(0, 0, 8'h5A);
		tick(1);
		chk("pointer", 8'h5A, ptr);
		hr(0, 1, 0, 8'hC3);
		hr(0, 0, 1, 8'h00);
		$display("test pointer done");
	endtask
	task automatic t_cs();
		hw(1, 0, 8'h77);
		hw(1, 1, 8'hEE);
		tick(1);
		chk("pointer kept", 8'h5A, ptr);
		hr(1, 1, 1, 8'h00);
		hr(0, 1, 0, 8'hC3);
		$display("test select done");
	endtask
	task automatic t_pins();
		@(posedge clk_i);
		{irq_i, mul_sel} <= 2'b11;
		tick(2);
		chk("irq", 8'h01, {7'h00, irq_o});
		chk("pll", 8'h01, {7'h00, pll});
		@(posedge clk_i);
		{irq_i, mul_sel} <= 2'b00;
		tick(2);
		chk("irq", 8'h00, {7'h00, irq_o});
		chk("pll", 8'h00, {7'h00, pll});
		$display("test pins done");
	endtask
	task automatic t_dma();
		logic seen;
		int nb;
		seen = 1'b0;
		nb = 0;
		@(posedge clk_i);
		job_r <= {1'b1, 1'b1, 8'h10, 16'h0003};
		@(posedge clk_i);
		job_r.start <= 1'b0;
		tick(1);
		chk("request", 8'h00, {7'h00, req_n});
		for (int i = 0; i < 60 && !seen; i++) begin
			tick(1);
			seen = (done === 1'b1);
		end
		chk("done seen", 8'h01, {7'h00, seen});
		chk("request off", 8'h01, {7'h00, req_n});
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i);
			caddr <= 8'h10 + i[7:0];
			tick(2);
			chk("dma byte", 8'h40 + i[7:0], crd);
		end
		// Same bytes sent back out: peer strobes the read line, bench watches the bus
		@(posedge clk_i);
		dma_rd <= 1'b1;
		job_r <= {1'b1, 1'b0, 8'h10, 16'h0003};
		@(posedge clk_i);
		job_r.start <= 1'b0;
		seen = 1'b0;
		for (int i = 0; i < 60 && !seen; i++) begin
			tick(1);
			if (!pstb_n && !gnt_n) begin
				chk("dma bus enable", 8'h00, {7'h00, oe_n});
				chk("dma read byte", 8'h40 + nb[7:0], dout);
				nb++;
			end
			seen = (done === 1'b1);
		end
		chk("dma read done", 8'h01, {7'h00, seen});
		chk("dma reads", 8'h03, nb[7:0]);
		@(posedge clk_i);
		dma_rd <= 1'b0;
		$display("test dma done");
	endtask
	task automatic t_rst();
		hw(0, 0, 8'h99);
		{irq_i, mul_sel} <= 2'b11;
		rst_b_i <= 1'b0;
		tick(1);
		chk("pointer", HBP_PTR_RST, ptr);
		chk("irq", 8'h00, {7'h00, irq_o});
		chk("pll", 8'h00, {7'h00, pll});
		chk("request", 8'h01, {7'h00, req_n});
		@(posedge clk_i);
		{rst_b_i, irq_i, mul_sel} <= 3'b100;
		hw(0, 0, 8'h21);
		tick(1);
		chk("pointer after reset", 8'h21, ptr);
		chk("irq after reset", 8'h00, {7'h00, irq_o});
		$display("test reset done");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog well past the expected hundred or so cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		err_count++;
		close_out();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_ptr();
		t_cs();
		t_pins();
		t_dma();
		t_rst();
		close_out();
	end
endmodule
